// file: src/ssr_pkg.sv
// Constants, register map and stage encodings for the slave stage reporter.
// Assumes a 32-bit register port with byte addresses and one clock domain.
package ssr_pkg;

    // ----------------------------------------------------------------
    // Bus widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int CODE_W = 16;
    localparam int NIB_W = 4;
    localparam int ACK_BIT = 4;
    localparam int GFLD_W = 16;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REQ_OFS = 16'h0120;
    localparam logic [ADDR_W-1:0] REP_OFS = 16'h0130;
    localparam logic [ADDR_W-1:0] CODE_OFS = 16'h0134;
    localparam logic [ADDR_W-1:0] GUARD_CFG_BASE = 16'h0800;
    localparam logic [ADDR_W-1:0] GUARD_EXP_BASE = 16'h0900;
    localparam logic [ADDR_W-1:0] GUARD_STRIDE = 16'h0010;
    localparam logic [ADDR_W-1:0] FLD_START = 16'h0000;
    localparam logic [ADDR_W-1:0] FLD_LEN = 16'h0004;
    localparam logic [ADDR_W-1:0] FLD_DIR = 16'h0008;

    // ----------------------------------------------------------------
    // Guard directions and reset values
    // ----------------------------------------------------------------
    localparam logic DIR_OUT = 1'b0;
    localparam logic DIR_IN = 1'b1;
    localparam logic [GFLD_W-1:0] GFLD_RST = 16'h0000;

    // ----------------------------------------------------------------
    // Stage request codes (low nibble of the request word)
    // ----------------------------------------------------------------
    localparam logic [NIB_W-1:0] NIB_BASE = 4'h1;
    localparam logic [NIB_W-1:0] NIB_MBOX = 4'h2;
    localparam logic [NIB_W-1:0] NIB_LOADER = 4'h3;
    localparam logic [NIB_W-1:0] NIB_INPUTS = 4'h4;
    localparam logic [NIB_W-1:0] NIB_FULL = 4'h8;

    typedef enum logic [4:0] {
        ST_BASE = 5'b00001,
        ST_MBOX = 5'b00010,
        ST_INPUTS = 5'b00100,
        ST_FULL = 5'b01000,
        ST_LOADER = 5'b10000
    } ssr_stage_t;

    // ----------------------------------------------------------------
    // Status codes
    // ----------------------------------------------------------------
    localparam logic [CODE_W-1:0] C_OK = 16'h0000;
    localparam logic [CODE_W-1:0] C_UNSPEC = 16'h0001;
    localparam logic [CODE_W-1:0] C_NO_MEM = 16'h0002;
    localparam logic [CODE_W-1:0] C_REVISION = 16'h0004;
    localparam logic [CODE_W-1:0] C_BAD_CHANGE = 16'h0011;
    localparam logic [CODE_W-1:0] C_UNKNOWN = 16'h0012;
    localparam logic [CODE_W-1:0] C_NO_LOADER = 16'h0013;
    localparam logic [CODE_W-1:0] C_NO_FW = 16'h0014;
    localparam logic [CODE_W-1:0] C_MBX_LOADER = 16'h0015;
    localparam logic [CODE_W-1:0] C_MBX_CFG = 16'h0016;

endpackage

// file: src/ssr_guard_chk.sv
// One mailbox buffer guard: programmed and expected start, length and direction.
// Assumes the register port of the parent; reads answer combinationally here
// and the parent registers the data.
module ssr_guard_chk #(
    parameter logic [ssr_pkg::ADDR_W-1:0] CFG_BASE = ssr_pkg::GUARD_CFG_BASE,
    parameter logic [ssr_pkg::ADDR_W-1:0] EXP_BASE = ssr_pkg::GUARD_EXP_BASE,
    parameter logic ROLE_DIR = ssr_pkg::DIR_OUT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ssr_pkg::ADDR_W-1:0] addr,
    input wire logic [ssr_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    output logic rd_hit,
    output logic [ssr_pkg::DATA_W-1:0] rd_data,
    output logic cfg_match
);

    typedef struct packed {
        logic [ssr_pkg::GFLD_W-1:0] act_start;
        logic [ssr_pkg::GFLD_W-1:0] act_len;
        logic act_dir;
        logic [ssr_pkg::GFLD_W-1:0] exp_start;
        logic [ssr_pkg::GFLD_W-1:0] exp_len;
        logic exp_dir;
    } ssr_gst_t;

    ssr_gst_t s_r;
    ssr_gst_t s_nxt;

    // ----------------------------------------------------------------
    // Register writes and read decode
    // ----------------------------------------------------------------
    // The expected set stands for what the local host wants to see.
    always_comb begin
        s_nxt = s_r;
        rd_hit = 1'b1;
        rd_data = '0;
        case (addr)
            CFG_BASE + ssr_pkg::FLD_START: rd_data[ssr_pkg::GFLD_W-1:0] = s_r.act_start;
            CFG_BASE + ssr_pkg::FLD_LEN: rd_data[ssr_pkg::GFLD_W-1:0] = s_r.act_len;
            CFG_BASE + ssr_pkg::FLD_DIR: rd_data[0] = s_r.act_dir;
            EXP_BASE + ssr_pkg::FLD_START: rd_data[ssr_pkg::GFLD_W-1:0] = s_r.exp_start;
            EXP_BASE + ssr_pkg::FLD_LEN: rd_data[ssr_pkg::GFLD_W-1:0] = s_r.exp_len;
            EXP_BASE + ssr_pkg::FLD_DIR: rd_data[0] = s_r.exp_dir;
            default: rd_hit = 1'b0;
        endcase
        if (wr) begin
            case (addr)
                CFG_BASE + ssr_pkg::FLD_START: s_nxt.act_start = wdata[ssr_pkg::GFLD_W-1:0]; // R14
                CFG_BASE + ssr_pkg::FLD_LEN: s_nxt.act_len = wdata[ssr_pkg::GFLD_W-1:0]; // R14
                CFG_BASE + ssr_pkg::FLD_DIR: s_nxt.act_dir = wdata[0]; // R14
                EXP_BASE + ssr_pkg::FLD_START: s_nxt.exp_start = wdata[ssr_pkg::GFLD_W-1:0];
                EXP_BASE + ssr_pkg::FLD_LEN: s_nxt.exp_len = wdata[ssr_pkg::GFLD_W-1:0];
                EXP_BASE + ssr_pkg::FLD_DIR: s_nxt.exp_dir = wdata[0];
                default: s_nxt = s_nxt;
            endcase
        end
    end

    // A guard that points the wrong way for its mailbox is a mismatch too.
    assign cfg_match = (s_r.act_start == s_r.exp_start) && (s_r.act_len == s_r.exp_len)
        && (s_r.act_dir == s_r.exp_dir) && (s_r.act_dir == ROLE_DIR); // R13

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '{ssr_pkg::GFLD_RST, ssr_pkg::GFLD_RST, ROLE_DIR,
                     ssr_pkg::GFLD_RST, ssr_pkg::GFLD_RST, ROLE_DIR};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    cfg_store_a: assert property (@(posedge clk) disable iff (rst) // R14
        wr && addr == CFG_BASE + ssr_pkg::FLD_LEN |=> s_r.act_len == $past(wdata[15:0]))
        else $error("guard length write was not stored");

endmodule

// file: src/ssr_top.sv
// Stage machine, transition checker and status-code reporter of a fieldbus slave.
// Assumes a register port with one-cycle strobes, and fault inputs that are
// one-cycle pulses synchronous to clk.
//
// Operation
// (R1) Request nibble 0x01 base, 0x02 mailbox-only, 0x03 loader stage.
// (R2) Request nibble 0x04 inputs-only, 0x08 full exchange stage.
// (R3) Master sets bit 4 of the request word to acknowledge an error.
// (R4) Report word carries the stage code, plus bit 4 when in error.
// (R5) Without error the code reads 0x0000 and the stage is unchanged.
// (R6) A fault without its own code reports 0x0001 and sets the error.
// (R7) Memory too small for downloaded content reports 0x0002 with error.
// (R8) Bad revision refuses mailbox-only to inputs-only with code 0x0004.
// (R9) Disallowed transitions give 0x0011; stage kept, error set.
// (R10) Undefined request values give 0x0012; stage kept, error set.
// (R11) Loader request without loader support gives 0x0013 in base stage.
// (R12) Unusable firmware refuses base to mailbox-only with code 0x0014.
// (R13) Two mailboxes, each guarded by a buffer guard of fixed direction.
// (R14) Guards are set up by start, length, direction registers at 0x0800.
// (R15) Guard mismatch on base to loader request reports 0x0015.
// (R16) Guard mismatch on base to inputs-only keeps base, code 0x0016.
// (R17) Master moves the slave one permitted step at a time.
// (R18) Master writes only the defined stage codes.
// (R19) From power-up stages run base, mailbox-only, inputs-only, full.
// (R20) Code and error flag hold until a write with acknowledge set.
module ssr_top #(
    parameter logic LOADER_EN = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ssr_pkg::ADDR_W-1:0] addr,
    input wire logic [ssr_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [ssr_pkg::DATA_W-1:0] rdata,
    input wire logic fault_unspec,
    input wire logic fault_no_mem,
    input wire logic revision_bad,
    input wire logic firmware_bad,
    output logic [ssr_pkg::NIB_W:0] stage_report,
    output logic [ssr_pkg::CODE_W-1:0] status_code,
    output logic err_flag
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        ssr_pkg::ssr_stage_t stage;
        logic err;
        logic [ssr_pkg::CODE_W-1:0] code;
        logic [ssr_pkg::DATA_W-1:0] req_word;
        logic [ssr_pkg::DATA_W-1:0] rdata;
    } ssr_st_t;

    ssr_st_t s_r;
    ssr_st_t s_nxt;
    logic out_hit;
    logic in_hit;
    logic [ssr_pkg::DATA_W-1:0] out_rd;
    logic [ssr_pkg::DATA_W-1:0] in_rd;
    logic out_ok;
    logic in_ok;
    logic mbx_ok;
    logic wr_req;
    logic [ssr_pkg::NIB_W-1:0] req_nib;
    logic req_clean;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [ssr_pkg::NIB_W-1:0] stage_nib(input ssr_pkg::ssr_stage_t st);
        case (st)
            ssr_pkg::ST_BASE: stage_nib = ssr_pkg::NIB_BASE; // R1
            ssr_pkg::ST_MBOX: stage_nib = ssr_pkg::NIB_MBOX; // R1
            ssr_pkg::ST_LOADER: stage_nib = ssr_pkg::NIB_LOADER; // R1
            ssr_pkg::ST_INPUTS: stage_nib = ssr_pkg::NIB_INPUTS; // R2
            ssr_pkg::ST_FULL: stage_nib = ssr_pkg::NIB_FULL; // R2
            default: stage_nib = ssr_pkg::NIB_BASE;
        endcase
    endfunction

    function automatic logic nib_known(input logic [ssr_pkg::NIB_W-1:0] n);
        nib_known = (n == ssr_pkg::NIB_BASE) || (n == ssr_pkg::NIB_MBOX)
            || (n == ssr_pkg::NIB_LOADER) || (n == ssr_pkg::NIB_INPUTS)
            || (n == ssr_pkg::NIB_FULL);
    endfunction

    function automatic ssr_pkg::ssr_stage_t nib_stage(input logic [ssr_pkg::NIB_W-1:0] n);
        case (n)
            ssr_pkg::NIB_MBOX: nib_stage = ssr_pkg::ST_MBOX;
            ssr_pkg::NIB_LOADER: nib_stage = ssr_pkg::ST_LOADER;
            ssr_pkg::NIB_INPUTS: nib_stage = ssr_pkg::ST_INPUTS;
            ssr_pkg::NIB_FULL: nib_stage = ssr_pkg::ST_FULL;
            default: nib_stage = ssr_pkg::ST_BASE;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Mailbox buffer guards
    // ----------------------------------------------------------------
    // Output mailbox carries master-to-slave traffic, input mailbox the reverse.
    ssr_guard_chk #(
        .CFG_BASE(ssr_pkg::GUARD_CFG_BASE),
        .EXP_BASE(ssr_pkg::GUARD_EXP_BASE),
        .ROLE_DIR(ssr_pkg::DIR_OUT)
    ) u_out_guard (
        .clk(clk),
        .rst(rst),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd_hit(out_hit),
        .rd_data(out_rd),
        .cfg_match(out_ok)
    );

    ssr_guard_chk #(
        .CFG_BASE(ssr_pkg::GUARD_CFG_BASE + ssr_pkg::GUARD_STRIDE),
        .EXP_BASE(ssr_pkg::GUARD_EXP_BASE + ssr_pkg::GUARD_STRIDE),
        .ROLE_DIR(ssr_pkg::DIR_IN)
    ) u_in_guard (
        .clk(clk),
        .rst(rst),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd_hit(in_hit),
        .rd_data(in_rd),
        .cfg_match(in_ok)
    );

    // Both guards must agree with the host's view before base may move to the loader stage.
    assign mbx_ok = out_ok && in_ok; // R13
    assign wr_req = wr && (addr == ssr_pkg::REQ_OFS);
    assign req_nib = wdata[ssr_pkg::NIB_W-1:0];
    assign req_clean = (wdata[ssr_pkg::DATA_W-1:ssr_pkg::ACK_BIT+1] == '0);

    // ----------------------------------------------------------------
    // Stage machine and status code
    // ----------------------------------------------------------------
    // A request is judged against the stage it was made in; a refused
    // request never moves the stage, it only posts the code and the flag.
    always_comb begin
        logic [ssr_pkg::CODE_W-1:0] rej;
        logic go;
        ssr_pkg::ssr_stage_t tgt;
        rej = ssr_pkg::C_OK;
        go = 1'b0;
        tgt = nib_stage(req_nib);
        s_nxt = s_r;
        if (wr_req) begin
            s_nxt.req_word = wdata;
            if (wdata[ssr_pkg::ACK_BIT]) begin
                s_nxt.err = 1'b0; // R20
                s_nxt.code = ssr_pkg::C_OK; // R5
            end
            if (!req_clean || !nib_known(req_nib)) begin
                rej = ssr_pkg::C_UNKNOWN; // R10
            end else if (tgt != s_r.stage) begin
                case (s_r.stage)
                    ssr_pkg::ST_BASE: begin
                        case (tgt)
                            ssr_pkg::ST_MBOX: begin
                                if (firmware_bad) begin
                                    rej = ssr_pkg::C_NO_FW; // R12
                                end else begin
                                    go = 1'b1; // R19
                                end
                            end
                            ssr_pkg::ST_LOADER: begin
                                if (!LOADER_EN) begin
                                    rej = ssr_pkg::C_NO_LOADER; // R11
                                end else if (!mbx_ok) begin
                                    rej = ssr_pkg::C_MBX_LOADER; // R15
                                end else begin
                                    go = 1'b1;
                                end
                            end
                            ssr_pkg::ST_INPUTS: begin
                                rej = mbx_ok ? ssr_pkg::C_BAD_CHANGE : ssr_pkg::C_MBX_CFG; // R16
                            end
                            default: rej = ssr_pkg::C_BAD_CHANGE; // R9
                        endcase
                    end
                    ssr_pkg::ST_MBOX: begin
                        case (tgt)
                            ssr_pkg::ST_BASE: go = 1'b1;
                            ssr_pkg::ST_INPUTS: begin
                                if (revision_bad) begin
                                    rej = ssr_pkg::C_REVISION; // R8
                                end else begin
                                    go = 1'b1; // R19
                                end
                            end
                            default: rej = ssr_pkg::C_BAD_CHANGE; // R9
                        endcase
                    end
                    ssr_pkg::ST_INPUTS, ssr_pkg::ST_FULL: begin
                        // Any step down is allowed; only the loader is out of reach.
                        if (tgt == ssr_pkg::ST_LOADER) begin
                            rej = ssr_pkg::C_BAD_CHANGE; // R9
                        end else begin
                            go = 1'b1; // R19
                        end
                    end
                    ssr_pkg::ST_LOADER: begin
                        if (tgt == ssr_pkg::ST_BASE) begin
                            go = 1'b1;
                        end else begin
                            rej = ssr_pkg::C_BAD_CHANGE; // R9
                        end
                    end
                    default: rej = ssr_pkg::C_BAD_CHANGE;
                endcase
            end
            if (rej != ssr_pkg::C_OK) begin
                s_nxt.err = 1'b1;
                s_nxt.code = rej;
            end else if (go) begin
                s_nxt.stage = tgt;
            end
        end
        // Application faults are applied after the acknowledge, so a fault
        // landing in the cycle of an accepted acknowledge is not lost; a refused request drops it.
        if (rej == ssr_pkg::C_OK) begin
            if (fault_no_mem) begin
                s_nxt.err = 1'b1; // R7
                s_nxt.code = ssr_pkg::C_NO_MEM; // R7
            end else if (fault_unspec) begin
                s_nxt.err = 1'b1; // R6
                s_nxt.code = ssr_pkg::C_UNSPEC; // R6
            end
        end
        // Read data stand in the cycle after the strobe only.
        s_nxt.rdata = '0;
        if (rd) begin
            case (addr)
                ssr_pkg::REQ_OFS: s_nxt.rdata = s_r.req_word;
                ssr_pkg::REP_OFS: s_nxt.rdata[ssr_pkg::NIB_W:0] = {s_r.err, stage_nib(s_r.stage)};
                ssr_pkg::CODE_OFS: s_nxt.rdata[ssr_pkg::CODE_W-1:0] = s_r.code;
                default: s_nxt.rdata = out_hit ? out_rd : (in_hit ? in_rd : '0);
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '{ssr_pkg::ST_BASE, 1'b0, ssr_pkg::C_OK, '0, '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rdata = s_r.rdata;
    assign stage_report = {s_r.err, stage_nib(s_r.stage)}; // R4
    assign status_code = s_r.code;
    assign err_flag = s_r.err;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_req_to(logic [3:0] n);
        wr_req && req_clean && req_nib == n;
    endsequence

    sequence s_quiet;
        !fault_unspec && !fault_no_mem;
    endsequence

    unknown_req_a: assert property ( // R10
        wr_req && !nib_known(req_nib) |=> err_flag && status_code == 16'h0012
            && s_r.stage == $past(s_r.stage))
        else $error("undefined request not rejected with 0x0012");

    base_full_a: assert property ( // R9
        s_r.stage == ssr_pkg::ST_BASE and s_req_to(4'h8) |=> status_code == 16'h0011
            && s_r.stage == ssr_pkg::ST_BASE && err_flag)
        else $error("base to full exchange not rejected");

    rev_refuse_a: assert property ( // R8
        s_r.stage == ssr_pkg::ST_MBOX && revision_bad and s_req_to(4'h4)
            |=> s_r.stage == ssr_pkg::ST_MBOX && status_code == 16'h0004)
        else $error("bad revision did not refuse the step");

    fw_refuse_a: assert property ( // R12
        s_r.stage == ssr_pkg::ST_BASE && firmware_bad and s_req_to(4'h2)
            |=> stage_report == 5'h11 && status_code == 16'h0014)
        else $error("bad firmware did not refuse the step");

    loader_unsup_a: assert property ( // R11
        !LOADER_EN && s_r.stage == ssr_pkg::ST_BASE and s_req_to(4'h3)
            |=> stage_report == 5'h11 && status_code == 16'h0013)
        else $error("loader request not refused with 0x0013");

    mbx_cfg_a: assert property ( // R16
        s_r.stage == ssr_pkg::ST_BASE && !mbx_ok and s_req_to(4'h4)
            |=> stage_report == 5'h11 && status_code == 16'h0016)
        else $error("guard mismatch not reported with 0x0016");

    loader_mbx_a: assert property ( // R15
        LOADER_EN && s_r.stage == ssr_pkg::ST_BASE && !mbx_ok and s_req_to(4'h3)
            |=> status_code == 16'h0015)
        else $error("guard mismatch on loader request not reported");

    // The master leaves one idle cycle between steps, and nothing else may move the stage.
    step_path_a: assert property ( // R19
        (s_r.stage == ssr_pkg::ST_BASE && !firmware_bad and s_req_to(4'h2)) ##1 !wr_req
            ##1 (!revision_bad and s_req_to(4'h4)) ##1 !wr_req ##1 s_req_to(4'h8)
            |=> stage_report[3:0] == 4'h8)
        else $error("step-wise start-up did not reach full exchange");

    code_hold_a: assert property ( // R20
        !wr_req and s_quiet |=> $stable(status_code) && $stable(err_flag)
            && $stable(s_r.stage))
        else $error("status code or stage changed without a cause");

    ack_clear_a: assert property ( // R20
        wr_req && wdata[4] && req_clean && req_nib == stage_report[3:0] and s_quiet
            |=> status_code == 16'h0000 && !err_flag)
        else $error("acknowledge did not clear the status code");

    nomem_a: assert property ( // R7
        fault_no_mem && !wr_req |=> err_flag && status_code == 16'h0002)
        else $error("memory fault not reported with 0x0002");

    unspec_a: assert property ( // R6
        fault_unspec && !fault_no_mem && !wr_req |=> err_flag && status_code == 16'h0001)
        else $error("unspecified fault not reported with 0x0001");

    report_read_a: assert property ( // R4
        rd && addr == ssr_pkg::REP_OFS |=> rdata[4:0] == $past(stage_report)
            && rdata[31:5] == '0)
        else $error("report word read returned wrong data");

endmodule

// file: testbench/ssr_master_model.sv
// Master model for the slave stage reporter: register-port writes and reads.
// Assumes the bench clock and a slave that never stalls the bus.
module ssr_master_model (
    input wire logic clk,
    output logic [ssr_pkg::ADDR_W-1:0] addr,
    output logic [ssr_pkg::DATA_W-1:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [ssr_pkg::DATA_W-1:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // The bus starts idle; a released address shows the inverse, not stale data.
    initial begin
        addr = 16'hFFFF;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
    end

    // One-cycle write strobe; the edge that ends it is when the write lands.
    task automatic put(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic get(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask

    // Requests carry a defined stage code and, when asked, the acknowledge bit.
    task automatic request(input logic [3:0] nib, input logic ack);
        put(ssr_pkg::REQ_OFS, {27'h0, ack, nib});
    endtask
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the slave stage reporter, one task per scenario.
// Assumes the master model in ssr_master_model; a second copy lacks loader support.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, wr, rd, fault_unspec, fault_no_mem, revision_bad, firmware_bad, err_flag;
    logic [15:0] addr, status_code, nl_code;
    logic [31:0] wdata, rdata, d;
    logic [4:0] stage_report, nl_report;
    int err_total, checks;

    ssr_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .fault_unspec(fault_unspec), .fault_no_mem(fault_no_mem),
        .revision_bad(revision_bad), .firmware_bad(firmware_bad),
        .stage_report(stage_report), .status_code(status_code), .err_flag(err_flag));
    ssr_master_model mm (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    // A copy without loader support sees the same bus; it tracks the first one until a loader request in base stage.
    ssr_top #(.LOADER_EN(1'b0)) dut_noload (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(), .fault_unspec(fault_unspec), .fault_no_mem(fault_no_mem),
        .revision_bad(revision_bad), .firmware_bad(firmware_bad),
        .stage_report(nl_report), .status_code(nl_code), .err_flag());

    // Free-running 250 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask

    // The flag must agree with bit 4 of the report, so all three are judged together.
    task automatic see(input logic [4:0] rep, input logic [15:0] code);
        cmp({27'h0, stage_report}, {27'h0, rep});
        cmp({16'h0, status_code}, {16'h0, code});
        cmp({31'h0, err_flag}, {31'h0, rep[4]});
    endtask

    task automatic t_walk;
        #1 see(5'h01, ssr_pkg::C_OK);
        mm.request(ssr_pkg::NIB_MBOX, 1'b0);
        see(5'h02, ssr_pkg::C_OK);
        mm.request(ssr_pkg::NIB_INPUTS, 1'b0);
        see(5'h04, ssr_pkg::C_OK);
        mm.request(ssr_pkg::NIB_FULL, 1'b0);
        see(5'h08, ssr_pkg::C_OK);
        mm.get(ssr_pkg::REP_OFS, d);
        cmp(d, 32'h8);
        $display("walk done");
    endtask

    task automatic t_refuse;
        mm.request(ssr_pkg::NIB_LOADER, 1'b0);
        see(5'h18, ssr_pkg::C_BAD_CHANGE);
        repeat (3) @(posedge clk);
        #1 see(5'h18, ssr_pkg::C_BAD_CHANGE);
        mm.request(ssr_pkg::NIB_FULL, 1'b1);
        see(5'h08, ssr_pkg::C_OK);
        mm.put(ssr_pkg::REQ_OFS, 32'h5);
        see(5'h18, ssr_pkg::C_UNKNOWN);
        mm.request(ssr_pkg::NIB_BASE, 1'b1);
        see(5'h01, ssr_pkg::C_OK);
        $display("refuse done");
    endtask

    // Fault inputs are single-cycle pulses on the clock edge.
    task automatic t_faults;
        @(posedge clk);
        fault_no_mem <= 1'b1;
        @(posedge clk);
        fault_no_mem <= 1'b0;
        #1 see(5'h11, ssr_pkg::C_NO_MEM);
        mm.request(ssr_pkg::NIB_BASE, 1'b1);
        @(posedge clk);
        fault_unspec <= 1'b1;
        @(posedge clk);
        fault_unspec <= 1'b0;
        #1 see(5'h11, ssr_pkg::C_UNSPEC);
        mm.request(ssr_pkg::NIB_BASE, 1'b1);
        see(5'h01, ssr_pkg::C_OK);
        $display("faults done");
    endtask

    task automatic t_firm_rev;
        @(posedge clk);
        firmware_bad <= 1'b1;
        mm.request(ssr_pkg::NIB_MBOX, 1'b0);
        see(5'h11, ssr_pkg::C_NO_FW);
        @(posedge clk);
        firmware_bad <= 1'b0;
        revision_bad <= 1'b1;
        mm.request(ssr_pkg::NIB_MBOX, 1'b1);
        mm.request(ssr_pkg::NIB_INPUTS, 1'b0);
        see(5'h12, ssr_pkg::C_REVISION);
        @(posedge clk);
        revision_bad <= 1'b0;
        mm.request(ssr_pkg::NIB_BASE, 1'b1);
        see(5'h01, ssr_pkg::C_OK);
        $display("firmware and revision done");
    endtask

    task automatic t_guard;
        mm.put(ssr_pkg::GUARD_CFG_BASE, 32'h10);
        mm.get(ssr_pkg::GUARD_CFG_BASE, d);
        cmp(d, 32'h10);
        mm.get(16'h0400, d);
        cmp(d, 32'h0);
        mm.request(ssr_pkg::NIB_INPUTS, 1'b0);
        see(5'h11, ssr_pkg::C_MBX_CFG);
        mm.request(ssr_pkg::NIB_LOADER, 1'b1);
        see(5'h11, ssr_pkg::C_MBX_LOADER);
        cmp({11'h0, nl_report, nl_code}, {11'h0, 5'h11, ssr_pkg::C_NO_LOADER});
        mm.put(ssr_pkg::GUARD_CFG_BASE, 32'h0);
        mm.request(ssr_pkg::NIB_LOADER, 1'b1);
        see(5'h03, ssr_pkg::C_OK);
        $display("guard done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence: twenty cycles of reset, then every scenario in turn.
    initial begin
        {fault_unspec, fault_no_mem, revision_bad, firmware_bad} = 4'h0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_walk();
        t_refuse();
        t_faults();
        t_firm_rev();
        t_guard();
        tally_and_finish();
    end

    // About 72 cycles are needed; a hang past 5000 cycles counts as a mismatch.
    initial begin
        #20000;
        err_total++;
        $display("BAD t=%0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
